// *** design/sas_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer import sas_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // core power state and wake
  input wire logic sleep_mode,
  output logic irq,
  output logic wake_request,
  output logic vector_request,
  output logic converting,
  // analog front end
  input wire logic rc_clock_pin,
  input wire logic cmp_above_pin,
  output sas_analog_type analog
);

  initial begin
    if (ADDR_W < 5) begin
      $error("ADDR_W must be at least 5");
    end
  end

  sas_regs_type st;
  sas_regs_type next_st;

  // divider terminal count for the oscillator codes
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    unique case (sel)
      CLK_OSC_DIV16: div_last = LAST_DIV16;
      CLK_OSC_DIV32: div_last = LAST_DIV32;
      CLK_OSC_DIV64: div_last = LAST_DIV64;
      default: div_last = LAST_DIV8; // 001 and unlisted codes
    endcase
  endfunction : div_last

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == CLK_RC_LOW_BITS);
  endfunction : is_rc

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [4:0] ofs);
    // word compare; upper address bits beyond the map must be zero
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[4:2]));
  endfunction : hit

  logic req;
  logic accept;
  logic rd_acc;
  logic wr_acc;
  logic wr_lane;
  logic rc_rise;
  logic tick;
  logic finish;
  logic stop_req;
  logic [31:0] rd_mux;

  // bus handshake: every access answers on its second cycle
  always_comb begin
    req = read | write;
    accept = req & st.ack;
    rd_acc = read & st.ack;
    wr_acc = write & st.ack;
    wr_lane = wr_acc & byteenable[0];
    waitrequest = req & ~st.ack;
    readdata = st.rdata;
  end

  // bit-period tick from the divider or the synchronised rc clock
  always_comb begin
    rc_rise = st.rc_s2 & ~st.rc_s3;
    if (is_rc(st.clk_sel)) begin
      tick = rc_rise;
    end else begin
      tick = (st.div_cnt == div_last(st.clk_sel));
    end
    finish = (st.state == ST_CONV) && tick &&
             (st.period == LAST_PERIOD);
  end

  // read data mux, captured in the first cycle of the access
  always_comb begin
    rd_mux = 32'h0000_0000; // unmapped and reserved bits read zero
    if (hit(address, OFS_CTRL_MAIN)) begin
      rd_mux[POS_POWER_ON] = st.power_on;
      rd_mux[POS_START] = st.start;
      rd_mux[POS_CHAN_LO +: 5] = st.channel;
    end else if (hit(address, OFS_CONFIG)) begin
      rd_mux[POS_CLKSEL_LO +: 3] = st.clk_sel;
    end else if (hit(address, OFS_RESULT_HIGH)) begin
      rd_mux[1:0] = st.result[9:8];
    end else if (hit(address, OFS_RESULT_LOW)) begin
      rd_mux[7:0] = st.result[7:0];
    end else if (hit(address, OFS_FLAG)) begin
      rd_mux[POS_COMPLETE] = st.complete_flag;
    end else if (hit(address, OFS_ENABLE)) begin
      rd_mux[POS_COMPLETE] = st.irq_enable;
    end else if (hit(address, OFS_IRQ_CTRL)) begin
      rd_mux[POS_PERIPH_EN] = st.periph_en;
      rd_mux[POS_GLOBAL_EN] = st.global_en;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    next_st = st;
    stop_req = 1'b0;

    // pins pass two flops before use
    next_st.cmp_s1 = cmp_above_pin;
    next_st.cmp_s2 = st.cmp_s1;
    next_st.rc_s1 = rc_clock_pin;
    next_st.rc_s2 = st.rc_s1;
    next_st.rc_s3 = st.rc_s2;

    // bus handshake and read capture
    next_st.ack = req & ~st.ack;
    if (req && !st.ack) begin
      next_st.rdata = rd_mux;
    end

    // register writes
    if (wr_lane && hit(address, OFS_CTRL_MAIN)) begin
      next_st.power_on = writedata[POS_POWER_ON];
      next_st.channel = writedata[POS_CHAN_LO +: 5];
      if (writedata[POS_START] && st.state == ST_IDLE &&
          writedata[POS_POWER_ON] && !sleep_mode) begin
        next_st.start = 1'b1;
        next_st.state = ST_CONV;
        next_st.period = 4'h0;
        next_st.div_cnt = 6'h00;
        next_st.sar = 10'h000;
        next_st.bit_sel = 10'h000;
      end else if (!writedata[POS_START] && st.state == ST_CONV) begin
        stop_req = 1'b1;
      end
      if (!writedata[POS_POWER_ON]) begin
        stop_req = 1'b1;
      end
    end
    if (wr_lane && hit(address, OFS_CONFIG)) begin
      next_st.clk_sel = writedata[POS_CLKSEL_LO +: 3];
    end
    if (wr_lane && hit(address, OFS_ENABLE)) begin
      next_st.irq_enable = writedata[POS_COMPLETE];
    end
    if (wr_lane && hit(address, OFS_IRQ_CTRL)) begin
      next_st.periph_en = writedata[POS_PERIPH_EN];
      next_st.global_en = writedata[POS_GLOBAL_EN];
    end

    // sleep removes the reference, so a running conversion is dropped
    if (sleep_mode && st.state == ST_CONV) begin
      stop_req = 1'b1;
    end

    // divider runs only while sequencing; idle restarts the phase
    if (st.state == ST_IDLE || tick) begin
      next_st.div_cnt = 6'h00;
    end else begin
      next_st.div_cnt = st.div_cnt + 6'h01;
    end

    // sequencer
    unique case (st.state)
      ST_IDLE: begin
      end
      ST_CONV: begin
        if (stop_req) begin
          // result left untouched on abort
          next_st.start = 1'b0;
          next_st.state = ST_ABORT;
          next_st.abort_cnt = 2'h0;
          next_st.div_cnt = 6'h00;
          next_st.bit_sel = 10'h000;
        end else if (tick) begin
          if (st.period == 4'h0) begin
            // disconnect period done, try the msb first
            next_st.bit_sel = SAR_MSB;
            next_st.sar = SAR_MSB;
          end else begin
            next_st.sar = (st.cmp_s2 ? st.sar : (st.sar & ~st.bit_sel)) |
                          (st.bit_sel >> 1);
            next_st.bit_sel = st.bit_sel >> 1;
          end
          next_st.period = st.period + 4'h1;
          if (finish) begin
            next_st.start = 1'b0;
            next_st.result = st.cmp_s2 ? st.sar :
                             (st.sar & ~st.bit_sel);
            next_st.state = ST_IDLE;
            next_st.period = 4'h0;
            next_st.bit_sel = 10'h000;
          end
        end
      end
      ST_ABORT: begin
        // two bit periods of settling before acquisition resumes
        if (tick) begin
          next_st.abort_cnt = st.abort_cnt + 2'h1;
          if (st.abort_cnt + 2'h1 == ABORT_PERIODS) begin
            next_st.state = ST_IDLE;
          end
        end
      end
    endcase

    // completion flag: read clears only what was seen, a new set wins
    if (rd_acc && hit(address, OFS_FLAG) && st.rdata[POS_COMPLETE]) begin
      next_st.complete_flag = 1'b0;
    end
    if (finish && !stop_req) begin
      next_st.complete_flag = 1'b1;
    end
  end

  // state register; reset puts the converter off and idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{
        power_on: 1'b0,
        start: 1'b0,
        channel: RST_CHANNEL,
        clk_sel: RST_CLKSEL,
        result: RST_RESULT,
        complete_flag: 1'b0,
        irq_enable: 1'b0,
        global_en: 1'b0,
        periph_en: 1'b0,
        state: ST_IDLE,
        period: 4'h0,
        abort_cnt: 2'h0,
        div_cnt: 6'h00,
        sar: 10'h000,
        bit_sel: 10'h000,
        ack: 1'b0,
        rdata: 32'h0000_0000,
        cmp_s1: 1'b0,
        cmp_s2: 1'b0,
        rc_s1: 1'b0,
        rc_s2: 1'b0,
        rc_s3: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // interrupt, wake and vector levels
  always_comb begin
    irq = st.complete_flag & st.irq_enable;
    wake_request = irq & sleep_mode;
    vector_request = irq & st.global_en & st.periph_en;
    converting = st.start;
  end

  // analog side: mux select, sample switch and trial code
  always_comb begin
    analog.channel = st.channel;
    // sampling only while powered and not converting or settling
    analog.sample_connect = st.power_on && (st.state == ST_IDLE);
    analog.dac_code = st.sar;
  end

endmodule : sas_sequencer
`default_nettype wire

// *** pkg/sas_pkg.sv ***
// Summary of operation
// - clock-select code picks osc/8,/16,/32,/64 or internal RC for bit period
// - one full 10-bit conversion takes eleven bit periods
// - completion flag is set at every conversion end, enabled or not
// - completion flag stays set until software clears it
// - flag plus enable while sleeping wakes the device
// - after wake, vectoring needs both global and peripheral enables
// - result right-justified over high and low bytes, upper six bits zero
// - converter works only while its power-on bit is one
// - writing one to start bit begins conversion; reads one while busy
// - at finish: clear start bit, set flag, load result bytes
// - clearing start early stops conversion; result keeps previous value
// - after abort wait two bit periods, then acquisition restarts
// - device reset returns all registers to reset values, converter off
// - no conversions take place during Sleep
// - 5-bit channel field in bits 6..2 of main control routes the input
package sas_pkg;

  // register byte offsets, one 32-bit word each
  localparam logic [4:0] OFS_CTRL_MAIN = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_RESULT_HIGH = 5'h08;
  localparam logic [4:0] OFS_RESULT_LOW = 5'h0c;
  localparam logic [4:0] OFS_FLAG = 5'h10;
  localparam logic [4:0] OFS_ENABLE = 5'h14;
  localparam logic [4:0] OFS_IRQ_CTRL = 5'h18;

  // field positions
  localparam int POS_POWER_ON = 0;
  localparam int POS_START = 1;
  localparam int POS_CHAN_LO = 2;
  localparam int POS_CLKSEL_LO = 4;
  localparam int POS_COMPLETE = 0;
  localparam int POS_PERIPH_EN = 6;
  localparam int POS_GLOBAL_EN = 7;

  // clock-select codes and the matching divider terminal counts
  localparam logic [2:0] CLK_OSC_DIV8 = 3'h1;
  localparam logic [2:0] CLK_OSC_DIV16 = 3'h5;
  localparam logic [2:0] CLK_OSC_DIV32 = 3'h2;
  localparam logic [2:0] CLK_OSC_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC_LOW_BITS = 2'h3;
  localparam logic [5:0] LAST_DIV8 = 6'h07;
  localparam logic [5:0] LAST_DIV16 = 6'h0f;
  localparam logic [5:0] LAST_DIV32 = 6'h1f;
  localparam logic [5:0] LAST_DIV64 = 6'h3f;

  // timing counts in bit periods
  localparam logic [3:0] LAST_PERIOD = 4'ha; // periods 0..10, eleven total
  localparam logic [1:0] ABORT_PERIODS = 2'h2;
  localparam logic [9:0] SAR_MSB = 10'h200;

  // reset values
  localparam logic [4:0] RST_CHANNEL = 5'h00;
  localparam logic [2:0] RST_CLKSEL = 3'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ABORT = 2'b11
  } sas_state_type;

  // signals toward the analog front end
  typedef struct packed {
    logic [4:0] channel;
    logic sample_connect;
    logic [9:0] dac_code;
  } sas_analog_type;

  // complete block state
  typedef struct packed {
    logic power_on;
    logic start;
    logic [4:0] channel;
    logic [2:0] clk_sel;
    logic [9:0] result;
    logic complete_flag;
    logic irq_enable;
    logic global_en;
    logic periph_en;
    sas_state_type state;
    logic [3:0] period;
    logic [1:0] abort_cnt;
    logic [5:0] div_cnt;
    logic [9:0] sar;
    logic [9:0] bit_sel;
    logic ack;
    logic [31:0] rdata;
    logic cmp_s1;
    logic cmp_s2;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
  } sas_regs_type;

endpackage : sas_pkg

// *** test/sas_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sas_checker import sas_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // core and converter state
  input wire logic sleep_mode,
  input wire logic irq,
  input wire logic wake_request,
  input wire logic vector_request,
  input wire logic converting,
  input wire sas_analog_type analog
);
  // one domain, so one clocking and one disable for all
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_clears: assert property (
    $past(rst) |-> !converting && !irq && !analog.sample_connect)
    else $error("state not cleared after reset");
  chk_no_sleep_start: assert property (
    $rose(converting) |-> !$past(sleep_mode))
    else $error("conversion began while sleeping");
  chk_start_cause: assert property (
    $rose(converting) |-> $past(write && address == OFS_CTRL_MAIN
      && writedata[1:0] == 2'h3))
    else $error("conversion began without a start write");
  chk_flag_sticky: assert property (
    $fell(irq) |-> $past(read && address == OFS_FLAG
      || write && address == OFS_ENABLE))
    else $error("interrupt dropped without software action");
  chk_wake_level: assert property (
    sleep_mode && irq |-> wake_request)
    else $error("no wake with flag and enable set");
  chk_vector_gate: assert property (
    vector_request |-> irq)
    else $error("vector without pending interrupt");
  chk_high_zero: assert property (
    read && !waitrequest && address == OFS_RESULT_HIGH
      |-> readdata[31:2] == 30'h0)
    else $error("upper bits of result high not zero");
  // shortest bit period is eight clocks, so two periods exceed eight
  chk_abort_wait: assert property (
    $fell(converting) && $past(write) |-> !analog.sample_connect [*8])
    else $error("acquisition resumed too soon after abort");
  chk_hold_open: assert property (
    converting |-> !analog.sample_connect)
    else $error("sampling switch closed during conversion");
endmodule : sas_checker
`default_nettype wire

bind sas_sequencer sas_checker #(.ADDR_W(ADDR_W)) sas_checker_i (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .sleep_mode(sleep_mode), .irq(irq), .wake_request(wake_request),
  .vector_request(vector_request), .converting(converting),
  .analog(analog));

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top import sas_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic sleep_mode = 1'b0;
  logic rc_clock_pin = 1'b0;
  logic cmp_above_pin = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, irq, wake_request, vector_request, converting;
  sas_analog_type analog;
  logic [9:0] vin = 10'h000;
  logic [9:0] prev;
  logic [2:0] rcd = 3'h0;
  logic [2:0] code [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int div [6] = '{8, 16, 32, 64, 8, 8};
  int bad_count = 0;
  int check_count = 0;
  int n;

  always #10 clk = ~clk;

  // rc clock of eight cycles; ideal comparator against the trial code
  always @(posedge clk) begin
    rcd <= rcd + 3'h1;
    rc_clock_pin <= rcd[2];
    cmp_above_pin <= (vin >= analog.dac_code);
  end

  sas_sequencer sas_sequencer_i (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_mode(sleep_mode), .irq(irq),
    .wake_request(wake_request), .vector_request(vector_request),
    .converting(converting), .rc_clock_pin(rc_clock_pin),
    .cmp_above_pin(cmp_above_pin), .analog(analog));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one access held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 40);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 40) begin
      bad_count++;
      end_sim();
    end
    @(posedge clk);
  endtask : bus

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rdc

  // bounded wait for the busy level to drop
  task automatic till_idle(output int c);
    c = 0;
    while (converting !== 1'b0 && c < 2000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 2000) begin
      bad_count++;
      end_sim();
    end
  endtask : till_idle

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // every offset after reset, the unmapped one at 0x1c included
    for (int a = 0; a < 32; a += 4) rdc(5'(a), 32'h0);
    $display("test reset values done");
    // each clock code, power on first and start in a later write
    for (int i = 0; i < 6; i++) begin
      vin <= 10'h2a5 + 10'(i * 37);
      bus(1'b1, OFS_CONFIG, {25'h0, code[i], 4'h0});
      bus(1'b1, OFS_CTRL_MAIN, {25'h0, 5'(i + 24), 2'h1});
      bus(1'b1, OFS_CTRL_MAIN, {25'h0, 5'(i + 24), 2'h3});
      chk("channel", 32'(i + 24), 32'(analog.channel));
      till_idle(n);
      chk("cycles", 32'h1, 32'(n >= 11 * div[i] - 8 && n <= 11 * div[i] + 8));
      rdc(OFS_RESULT_HIGH, {30'h0, vin[9:8]});
      rdc(OFS_RESULT_LOW, {24'h0, vin[7:0]});
      rdc(OFS_FLAG, 32'h1);
      rdc(OFS_FLAG, 32'h0);
      rdc(OFS_CTRL_MAIN, {25'h0, 5'(i + 24), 2'h1});
    end
    $display("test clock codes done");
    // interrupt, wake and vector gating
    bus(1'b1, OFS_CONFIG, 32'h10);
    bus(1'b1, OFS_ENABLE, 32'h1);
    bus(1'b1, OFS_IRQ_CTRL, 32'hc0);
    bus(1'b1, OFS_CTRL_MAIN, 32'h3);
    till_idle(n);
    chk("vector", 32'h1, 32'(vector_request));
    sleep_mode <= 1'b1;
    @(posedge clk);
    chk("wake", 32'h1, 32'(wake_request));
    bus(1'b1, OFS_IRQ_CTRL, 32'h40);
    chk("vector", 32'h0, 32'(vector_request));
    bus(1'b1, OFS_ENABLE, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    bus(1'b1, OFS_ENABLE, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, OFS_CTRL_MAIN, 32'h3);
    chk("busy", 32'h0, 32'(converting));
    rdc(OFS_FLAG, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    sleep_mode <= 1'b0;
    $display("test interrupt done");
    // abort part way: old result kept, no flag, delayed acquisition
    prev = vin;
    vin <= 10'h155;
    bus(1'b1, OFS_CTRL_MAIN, 32'h3);
    rdc(OFS_CTRL_MAIN, 32'h3);
    bus(1'b1, OFS_CTRL_MAIN, 32'h1);
    n = 0;
    while (analog.sample_connect !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("abort wait", 32'h1, 32'(n >= 9 && n <= 20));
    rdc(OFS_RESULT_LOW, {24'h0, prev[7:0]});
    rdc(OFS_FLAG, 32'h0);
    $display("test abort done");
    // reset in mid conversion
    bus(1'b1, OFS_CTRL_MAIN, 32'h3);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("busy", 32'h0, 32'(converting));
    rdc(OFS_CTRL_MAIN, 32'h0);
    rdc(OFS_ENABLE, 32'h0);
    $display("test reset mid conversion done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
